// ---- hw/sync_serial_port_regs.vh ----
// Register offsets, field positions and reset values for the synchronous serial port
`ifndef SYNC_SERIAL_PORT_REGS_VH
`define SYNC_SERIAL_PORT_REGS_VH

// Byte offsets on the register bus, one word per register
`define ADDR_RX_STATUS_CONTROL 4'h0
`define ADDR_RX_HOLDING        4'h4
`define ADDR_TX_STATUS_CONTROL 4'h8
`define ADDR_BAUD_CONTROL      4'hC

// Second address nibble group
`define ADDR_DIVISOR_HIGH      5'h10
`define ADDR_DIVISOR_LOW       5'h14
`define ADDR_TX_HOLDING        5'h18
`define ADDR_IRQ_CONTROL       5'h1C

// Receive status/control fields
`define RSC_PORT_EN     7
`define RSC_NINE_BIT    6
`define RSC_SINGLE_EN   5
`define RSC_CONT_EN     4
`define RSC_FRAMING     2
`define RSC_OVERRUN     1
`define RSC_NINTH       0

// Transmit status/control fields
`define TSC_CLK_SOURCE  7
`define TSC_NINE_BIT    6
`define TSC_TX_EN       5
`define TSC_SYNC_MODE   4
`define TSC_SHIFT_EMPTY 1
`define TSC_NINTH       0

// Baud control fields
`define BC_IDLE_POL     4
`define BC_WIDE_DIV     3

// Interrupt control fields (flags read-only, enables writable)
`define IC_RX_IE        0
`define IC_TX_IE        1
`define IC_RX_FLAG      4
`define IC_TX_FLAG      5

// Reset values
`define RESET_BYTE      8'h00
`define RESET_TSC       8'h02

`endif

// ---- hw/sync_serial_port.v ----
// Synchronous half-duplex serial port with Wishbone register access
// How it works
// - In master mode either receive enable starts clocked reception
// - Sample data on falling shift clock edge
// - Single enable receives one word, then stops
// - Continuous enable receives until software clears it
// - Both enables set behaves as continuous
// - Completed word sets receive flag, maybe interrupt
// - Ninth bit and errors readable in status
// - Holding register read returns 8-bit word
// - Clearing continuous enable clears latched errors
// - Clock source cleared means external shift clock
// - Slave shifts words while chip sleeps
// - Two queued words: first sends, flag stays clear
// - Second word loads, then transmit flag sets
// - Transmit flag with enable wakes chip
// - Slave reception ignores single receive enable
// - Slave continuous reception works in low power
// - Low-power word moves to holding, wakes chip
// - Nine-bit option keeps ninth bit separate
// - Master rate from divisor, eight or sixteen bit
// - Slave transmit matches master transmit
// - Master drives the shift clock pin
// - Idle polarity sets clock pin idle level
// - Transmit flag set on empty, cleared by write
// - Shift empty flag shows empty shift register
`timescale 1ns/1ns
`default_nettype none
`include "sync_serial_port_regs.vh"

module sync_serial_port (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [4:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output wire        ack_o,
    // Shift clock pin
    input  wire        shift_clock_pin_i,
    output wire        shift_clock_pin_o,
    output wire        shift_clock_pin_oe_o,
    // Serial data pin
    input  wire        serial_data_pin_i,
    output wire        serial_data_pin_o,
    output wire        serial_data_pin_oe_o,
    // Interrupt request and wake-up
    output wire        irq_o
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_DONE  = 3'b100;

    // Registers
    reg  [7:0]  rsc_ff;             // port_en, nine, single, cont; low four bits held zero
    reg  [7:0]  tsc_ff;             // clk_src, nine, tx_en, sync
    reg  [7:0]  baud_ff;
    reg  [7:0]  div_hi_ff;
    reg  [7:0]  div_lo_ff;
    reg  [1:0]  ie_ff;
    reg  [7:0]  rx_hold_ff;
    reg         rx_ninth_ff;
    reg         rx_full_ff;         // receive_flag
    reg         overrun_ff;
    reg  [7:0]  tx_hold_ff;
    reg         tx_hold_ninth_ff;
    reg         tx_hold_full_ff;
    reg  [8:0]  tx_shift_ff;
    reg         tx_busy_ff;
    reg  [8:0]  rx_shift_ff;
    reg  [3:0]  bit_cnt_ff;
    reg  [2:0]  state_ff;
    reg         ack_ff;
    reg         sclk_ff;            // Internal master clock level
    reg  [15:0] div_cnt_ff;
    reg         ck_meta_ff;
    reg         ck_sync_ff;
    reg         ck_prev_ff;
    reg         dt_meta_ff;
    reg         dt_sync_ff;

    wire        port_en   = rsc_ff[`RSC_PORT_EN];
    wire        nine_rx   = rsc_ff[`RSC_NINE_BIT];
    wire        single_en = rsc_ff[`RSC_SINGLE_EN];
    wire        cont_en   = rsc_ff[`RSC_CONT_EN];
    wire        master    = tsc_ff[`TSC_CLK_SOURCE];
    wire        nine_tx   = tsc_ff[`TSC_NINE_BIT];
    wire        tx_en     = tsc_ff[`TSC_TX_EN];
    wire        idle_pol  = baud_ff[`BC_IDLE_POL];
    wire        wide_div  = baud_ff[`BC_WIDE_DIV];
    wire        active    = port_en & tsc_ff[`TSC_SYNC_MODE];

    // reception enable; continuous wins; slave ignores single
    wire        rx_mode   = active & (cont_en | (single_en & master));
    wire        tx_mode   = active & tx_en & ~rx_mode & ~(master & single_en);

    // Bus decode
    wire        bus_req   = cyc_i & stb_i & ~ack_ff;
    wire        wr_req    = bus_req & we_i & sel_i[0];
    wire        rd_req    = bus_req & ~we_i;
    wire        wr_rsc    = wr_req & (adr_i == {1'b0, `ADDR_RX_STATUS_CONTROL});
    wire        wr_tsc    = wr_req & (adr_i == {1'b0, `ADDR_TX_STATUS_CONTROL});
    wire        wr_baud   = wr_req & (adr_i == {1'b0, `ADDR_BAUD_CONTROL});
    wire        wr_hi     = wr_req & (adr_i == `ADDR_DIVISOR_HIGH);
    wire        wr_lo     = wr_req & (adr_i == `ADDR_DIVISOR_LOW);
    wire        wr_txh    = wr_req & (adr_i == `ADDR_TX_HOLDING);
    wire        wr_irq    = wr_req & (adr_i == `ADDR_IRQ_CONTROL);
    wire        rd_rxh    = rd_req & (adr_i == {1'b0, `ADDR_RX_HOLDING});

    wire [15:0] div_val   = wide_div ? {div_hi_ff, div_lo_ff} : {8'h00, div_lo_ff};

    // Shift clock edges: master from divider, slave from synchronised pin
    wire        div_tick  = (div_cnt_ff == div_val);
    wire        run_clk   = master & (state_ff == ST_SHIFT);
    wire        m_rise    = run_clk & div_tick & ~sclk_ff;
    wire        m_fall    = run_clk & div_tick & sclk_ff;
    wire        s_rise    = ~master & ck_sync_ff & ~ck_prev_ff;
    wire        s_fall    = ~master & ~ck_sync_ff & ck_prev_ff;
    wire        sh_rise   = m_rise | s_rise;
    wire        sh_fall   = m_fall | s_fall;

    wire [3:0]  rx_bits   = nine_rx ? 4'h9 : 4'h8;
    wire [3:0]  tx_bits   = nine_tx ? 4'h9 : 4'h8;
    wire [3:0]  last_bit  = rx_mode ? rx_bits : tx_bits;
    wire        word_end  = sh_fall & (bit_cnt_ff == last_bit - 4'h1);
    wire        rx_done   = word_end & rx_mode;
    wire        tx_done   = word_end & ~rx_mode;
    wire        tx_load   = tx_hold_full_ff & ~tx_busy_ff & tx_mode & (state_ff == ST_IDLE);

    // master drives clock; idle polarity; slave releases pin
    assign shift_clock_pin_oe_o = active & master;
    assign shift_clock_pin_o    = sclk_ff ^ idle_pol;
    assign serial_data_pin_oe_o = active & tx_busy_ff & ~rx_mode;
    assign serial_data_pin_o    = tx_shift_ff[0];
    assign ack_o                = ack_ff;

    // flags gated by enables form the wake-up interrupt
    assign irq_o = (rx_full_ff & ie_ff[`IC_RX_IE]) | (~tx_hold_full_ff & ie_ff[`IC_TX_IE] & active & tx_en);

    // Two-flop synchronisers for the pin inputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            ck_meta_ff <= 1'b0;
            ck_sync_ff <= 1'b0;
            ck_prev_ff <= 1'b0;
            dt_meta_ff <= 1'b0;
            dt_sync_ff <= 1'b0;
        end else begin
            ck_meta_ff <= shift_clock_pin_i ^ idle_pol;  // Normalise to idle-low
            ck_sync_ff <= ck_meta_ff;
            ck_prev_ff <= ck_sync_ff;
            dt_meta_ff <= serial_data_pin_i;
            dt_sync_ff <= dt_meta_ff;
        end
    end

    // Master divider: half period of the shift clock per divisor reload
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_ff <= 16'h0000;
            sclk_ff    <= 1'b0;
        end else if (!run_clk) begin
            // clock parks at idle level when not shifting
            div_cnt_ff <= 16'h0000;
            sclk_ff    <= 1'b0;
        end else if (div_tick) begin
            div_cnt_ff <= 16'h0000;
            sclk_ff    <= ~sclk_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 16'h0001;
        end
    end

    // Word sequencer
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff    <= ST_IDLE;
            bit_cnt_ff  <= 4'h0;
            rx_shift_ff <= 9'h000;
            tx_shift_ff <= 9'h000;
            tx_busy_ff  <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    bit_cnt_ff <= 4'h0;
                    if (tx_load) begin
                        tx_shift_ff <= {tx_hold_ninth_ff, tx_hold_ff};
                        tx_busy_ff  <= 1'b1;
                        state_ff    <= ST_SHIFT;
                    // slave reception runs off the outside clock
                    end else if (rx_mode) begin
                        state_ff <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (!(rx_mode | tx_busy_ff) || !active) begin
                        tx_busy_ff <= 1'b0;
                        state_ff   <= ST_IDLE;
                    end else if (sh_fall) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        // sample on falling shift clock edge
                        if (rx_mode) begin
                            rx_shift_ff <= {dt_sync_ff, rx_shift_ff[8:1]};
                        end else begin
                            tx_shift_ff <= {1'b0, tx_shift_ff[8:1]};
                        end
                        if (word_end) begin
                            state_ff <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    tx_busy_ff <= 1'b0;
                    state_ff   <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Completed-word alignment: nine-bit words have eight data bits shifted in, eight-bit take the last from the line
    wire [7:0] rx_byte  = nine_rx ? rx_shift_ff[8:1] : {dt_sync_ff, rx_shift_ff[8:2]};
    wire       rx_ninth = dt_sync_ff;

    // Receive holding, flags and errors
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_hold_ff  <= `RESET_BYTE;
            rx_ninth_ff <= 1'b0;
            rx_full_ff  <= 1'b0;
            overrun_ff  <= 1'b0;
        end else begin
            // overrun keeps old word and discards the new
            if (rx_done && rx_full_ff && !rd_rxh) begin
                overrun_ff <= 1'b1;
            end else if (wr_rsc && !dat_i[`RSC_CONT_EN]) begin
                overrun_ff <= 1'b0;
            end
            // word moves to holding, flag set wins over read
            if (rx_done && (!rx_full_ff || rd_rxh)) begin
                rx_hold_ff  <= rx_byte;
                rx_ninth_ff <= nine_rx & rx_ninth;
                rx_full_ff  <= 1'b1;
            end else if (rd_rxh) begin
                rx_full_ff <= 1'b0;
            end
        end
    end

    // Transmit holding register
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_hold_ff       <= `RESET_BYTE;
            tx_hold_ninth_ff <= 1'b0;
            tx_hold_full_ff  <= 1'b0;
        end else if (wr_txh) begin
            // only a data write clears the transmit flag
            tx_hold_ff       <= dat_i[7:0];
            tx_hold_ninth_ff <= tsc_ff[`TSC_NINTH];
            tx_hold_full_ff  <= 1'b1;
        end else if (tx_load) begin
            tx_hold_full_ff <= 1'b0;
        end
    end

    // Control registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            rsc_ff    <= `RESET_BYTE;
            tsc_ff    <= `RESET_BYTE;
            baud_ff   <= `RESET_BYTE;
            div_hi_ff <= `RESET_BYTE;
            div_lo_ff <= `RESET_BYTE;
            ie_ff     <= 2'b00;
        end else begin
            if (wr_rsc) begin
                rsc_ff <= {dat_i[7:4], 4'h0};
            // single receive drops itself after one word
            end else if (rx_done && !cont_en) begin
                rsc_ff[`RSC_SINGLE_EN] <= 1'b0;
            end
            if (wr_tsc) begin
                tsc_ff <= {dat_i[7:4], 3'b000, dat_i[0]};
            end
            if (wr_baud) begin
                baud_ff <= {3'b000, dat_i[4:3], 3'b000};
            end
            if (wr_hi) begin
                div_hi_ff <= dat_i[7:0];
            end
            if (wr_lo) begin
                div_lo_ff <= dat_i[7:0];
            end
            if (wr_irq) begin
                ie_ff <= dat_i[1:0];
            end
        end
    end

    // Bus answer: one wait cycle, reads registered with the ack
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_o  <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req;
            dat_o  <= 32'h0000_0000;
            if (rd_req) begin
                case (adr_i)
                    // ninth bit and errors in status
                    {1'b0, `ADDR_RX_STATUS_CONTROL}: dat_o[7:0] <= {rsc_ff[7:4], 1'b0, 1'b0, overrun_ff, rx_ninth_ff};
                    {1'b0, `ADDR_RX_HOLDING}:        dat_o[7:0] <= rx_hold_ff;
                    {1'b0, `ADDR_TX_STATUS_CONTROL}: dat_o[7:0] <= {tsc_ff[7:4], 2'b00, ~tx_busy_ff, tsc_ff[0]};
                    {1'b0, `ADDR_BAUD_CONTROL}:      dat_o[7:0] <= baud_ff;
                    `ADDR_DIVISOR_HIGH:              dat_o[7:0] <= div_hi_ff;
                    `ADDR_DIVISOR_LOW:               dat_o[7:0] <= div_lo_ff;
                    `ADDR_IRQ_CONTROL:               dat_o[7:0] <= {2'b00, ~tx_hold_full_ff, rx_full_ff, 2'b00, ie_ff};
                    default:                         dat_o[7:0] <= 8'h00;
                endcase
            end
        end
    end

endmodule // sync_serial_port
`default_nettype wire

// ---- sim/sync_serial_port_chk.sv ----
// Bus and pin assertions for the synchronous serial port
`timescale 1ns/1ns
`default_nettype none
module sync_serial_port_chk (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Register bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [4:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Pins and interrupt
    input wire logic        shift_clock_pin_o,
    input wire logic        shift_clock_pin_oe_o,
    input wire logic        serial_data_pin_oe_o,
    input wire logic        irq_o
);
    wire        take = cyc_i && stb_i && !ack_o;
    wire        wr = take && we_i && sel_i[0];
    logic       port_ff, mast_ff, act1_ff, act2_ff, transmit_enable_ff, rdbc_ff;
    logic [1:0] ie_ff, bc_ff;
    logic [7:0] lo_ff;
    wire        act = port_ff && mast_ff;
    // Shadow of control bits, taken on the same edge as the design
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {port_ff, mast_ff, act1_ff, act2_ff, transmit_enable_ff, rdbc_ff} <= 6'h00;
            {ie_ff, bc_ff, lo_ff} <= 12'h000;
        end else begin
            if (wr && adr_i == 5'h00) port_ff <= dat_i[7];
            if (wr && adr_i == 5'h08) {mast_ff, transmit_enable_ff} <= {dat_i[7] & dat_i[4], dat_i[5]};
            if (wr && adr_i == 5'h0C) bc_ff <= dat_i[4:3];
            if (wr && adr_i == 5'h14) lo_ff <= dat_i[7:0];
            if (wr && adr_i == 5'h1C) ie_ff <= dat_i[1:0];
            {act1_ff, act2_ff} <= {act, act1_ff};
            rdbc_ff <= take && !we_i && adr_i == 5'h0C;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next_cycle: assert property (take |=> ack_o) else $error("no ack");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_read_upper_zero: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h000000) else $error("upper bits");
    a_baud_read_back: assert property (rdbc_ff |-> ack_o && dat_o[7:0] == {3'h0, bc_ff, 3'h0}) else $error("baud");
    a_master_drives_clk: assert property (act && act2_ff |-> shift_clock_pin_oe_o) else $error("clk undriven");
    a_slave_frees_clk: assert property (!act && !act2_ff |-> !shift_clock_pin_oe_o) else $error("clk driven");
    a_half_period: assert property ($changed(shift_clock_pin_o) && act && act2_ff && lo_ff == 8'h03 && !bc_ff[0]
        |=> $stable(shift_clock_pin_o)[*3]) else $error("half period");
    a_tx_needs_enable: assert property (serial_data_pin_oe_o |-> transmit_enable_ff) else $error("data driven");
    a_irq_needs_enable: assert property (irq_o |-> ie_ff != 2'b00) else $error("irq unmasked");
    cover property ($rose(irq_o));
    cover property ($rose(serial_data_pin_oe_o));
    cover property (act2_ff && $changed(shift_clock_pin_o));
endmodule  // sync_serial_port_chk
bind sync_serial_port sync_serial_port_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .shift_clock_pin_o, .shift_clock_pin_oe_o, .serial_data_pin_oe_o, .irq_o);
`default_nettype wire

// ---- sim/serial_partner.sv ----
// Far-side serial device model: clocks frames and shifts data both ways
`timescale 1ns/1ns
`default_nettype none
module serial_partner (
    // Clock
    input  wire logic        clk_i,
    // Bench control
    input  wire logic        go_i,
    input  wire logic [4:0]  pulses_i,
    input  wire logic        drv_i,
    input  wire logic [17:0] tx_i,
    // Line side
    input  wire logic        ck_i,
    input  wire logic        dt_i,
    output logic             ck_o,
    output logic             dt_o,
    output logic             busy_o,
    output logic [15:0]      rx_o
);
    logic [17:0] sh_ff = 18'h00000;
    logic [5:0]  left_ff = 6'h00;
    logic [2:0]  div_ff = 3'h0;
    logic        ckq_ff = 1'b0;
    wire         rise = ck_i && !ckq_ff;
    initial {ck_o, dt_o, rx_o} = 18'h00000;
    assign busy_o = left_ff != 6'h00;
    // frame clock, eight-cycle halves, still between frames
    always @(posedge clk_i) begin
        ckq_ff <= ck_i;
        div_ff <= go_i ? 3'h0 : div_ff + 3'h1;
        if (go_i) begin
            left_ff <= {pulses_i, 1'b1};  // Last half idle, lets flags settle
        end else if (busy_o && div_ff == 3'h7) begin
            left_ff <= left_ff - 6'h01;
            ck_o <= (left_ff != 6'h01) ? !ck_o : ck_o;
        end
    end
    // data moves on rising edges, steady at falling ones
    always @(posedge clk_i) begin
        if (!drv_i) begin
            sh_ff <= tx_i;
            dt_o <= !dt_o;  // Released line toggles, never a stale bit
        end else if (rise) begin
            dt_o <= sh_ff[0];
            sh_ff <= {!sh_ff[0], sh_ff[17:1]};
        end
        rx_o <= go_i ? 16'h0000 : (rise ? {dt_i, rx_o[15:1]} : rx_o);
    end
endmodule  // serial_partner
`default_nettype wire

// ---- sim/sync_serial_port_test.sv ----
// Self-checking bench: register traffic plus far-side frames
`timescale 1ns/1ns
`default_nettype none
`include "sync_serial_port_regs.vh"
module sync_serial_port_test;
    logic        clk_i = 1'b0;
    logic        rst_i, cyc_i, stb_i, we_i, go, drv;
    logic [4:0]  adr_i, pulses;
    logic [3:0]  sel_i;
    logic [31:0] dat_i;
    logic [17:0] tx;
    logic [7:0]  b1, b2;
    logic [31:0] exp_q[$];
    int          error_cnt = 0;
    int          n_compared = 0;
    wire  [31:0] dat_o;
    wire  [15:0] p_rx;
    wire         ack_o, ck_o, ck_oe, dt_o, dt_oe, irq_o, p_ck, p_dt, p_busy;
    // Pin levels resolved from the port's output enables, far side otherwise
    wire         ck_line = ck_oe ? ck_o : p_ck;
    wire         dt_line = dt_oe ? dt_o : p_dt;
    always #10 clk_i = !clk_i;
    sync_serial_port u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .shift_clock_pin_i(ck_line), .shift_clock_pin_o(ck_o), .shift_clock_pin_oe_o(ck_oe),
        .serial_data_pin_i(dt_line), .serial_data_pin_o(dt_o), .serial_data_pin_oe_o(dt_oe), .irq_o);
    serial_partner u_far (.clk_i, .go_i(go), .pulses_i(pulses), .drv_i(drv), .tx_i(tx), .ck_i(ck_line),
        .dt_i(dt_line), .ck_o(p_ck), .dt_o(p_dt), .busy_o(p_busy), .rx_o(p_rx));
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            error_cnt++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, want);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h000000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        wb(1'b0, a, 8'h00);
    endtask
    task automatic frame(input logic [4:0] n);
        @(posedge clk_i);
        {go, pulses} <= {1'b1, n};
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge clk_i);
        while (p_busy) @(posedge clk_i);
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Read data checked in arrival order against the oldest note
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o, exp_q.pop_front());
    end
    // Watchdog well beyond the several hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        close_out();
    end
    // Main sequence
    initial begin
        {rst_i, cyc_i, stb_i, we_i, go, drv} = 6'b100000;
        {adr_i, pulses, dat_i, tx} = '0;
        sel_i = 4'hF;
        void'($urandom(31959));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(5'(`ADDR_TX_STATUS_CONTROL), `RESET_TSC);
        rd(5'h1D, 8'h00);
        // master setup, both receive enables clear
        wb(1'b1, `ADDR_DIVISOR_LOW, 8'h03);
        wb(1'b1, 5'(`ADDR_TX_STATUS_CONTROL), 8'h90);
        wb(1'b1, 5'(`ADDR_RX_STATUS_CONTROL), 8'h80);
        wb(1'b1, 5'(`ADDR_BAUD_CONTROL), 8'h10);
        rd(5'(`ADDR_BAUD_CONTROL), 8'h10);
        chk(ck_line, 1'b1);
        wb(1'b1, 5'(`ADDR_BAUD_CONTROL), 8'h00);
        wb(1'b1, `ADDR_IRQ_CONTROL, 8'h01);
        chk(ck_line, 1'b0);
        b1 = 8'($urandom);
        tx <= {10'h000, b1};
        @(posedge clk_i);
        drv <= 1'b1;
        wb(1'b1, 5'(`ADDR_RX_STATUS_CONTROL), 8'hA0);
        while (irq_o !== 1'b1) @(posedge clk_i);
        rd(5'(`ADDR_RX_STATUS_CONTROL), 8'h80);
        rd(`ADDR_IRQ_CONTROL, 8'h31);
        rd(5'(`ADDR_RX_HOLDING), b1);
        rd(`ADDR_IRQ_CONTROL, 8'h21);
        drv <= 1'b0;
        // Slave nine-bit continuous receive; second word overruns
        b2 = 8'($urandom);
        tx <= {1'b0, b2, 1'b1, b1};
        wb(1'b1, 5'(`ADDR_TX_STATUS_CONTROL), 8'h10);
        wb(1'b1, 5'(`ADDR_RX_STATUS_CONTROL), 8'hD0);
        drv <= 1'b1;
        frame(5'd18);
        rd(5'(`ADDR_RX_STATUS_CONTROL), 8'hD3);
        rd(5'(`ADDR_RX_HOLDING), b1);
        wb(1'b1, 5'(`ADDR_RX_STATUS_CONTROL), 8'hC0);
        rd(5'(`ADDR_RX_STATUS_CONTROL), 8'hC1);
        drv <= 1'b0;
        // slave transmit, two words queued before the far side clocks
        wb(1'b1, 5'(`ADDR_RX_STATUS_CONTROL), 8'h80);
        wb(1'b1, 5'(`ADDR_TX_STATUS_CONTROL), 8'h30);
        wb(1'b1, `ADDR_IRQ_CONTROL, 8'h02);
        wb(1'b1, `ADDR_TX_HOLDING, b2);
        wb(1'b1, `ADDR_TX_HOLDING, b1);
        rd(`ADDR_IRQ_CONTROL, 8'h02);
        rd(5'(`ADDR_TX_STATUS_CONTROL), 8'h30);
        frame(5'd16);
        chk(p_rx, {16'h0000, b1, b2});
        rd(`ADDR_IRQ_CONTROL, 8'h22);
        chk(irq_o, 1'b1);
        rd(5'(`ADDR_TX_STATUS_CONTROL), 8'h32);
        close_out();
    end
endmodule  // sync_serial_port_test
`default_nettype wire
